// *** hw/brp_pkg.sv ***
`default_nettype none
package brp_pkg;

  // Byte width of the multiplexed port and of each address half.
  localparam int BRP_BYTE_W = 8;
  localparam int BRP_ADDR_W = 16;
  localparam int BRP_ADDR_HI_MSB = 15;
  localparam int BRP_ADDR_HI_LSB = 8;
  localparam int BRP_ADDR_LO_MSB = 7;
  localparam int BRP_ADDR_LO_LSB = 0;

  // ROM access time in ns, turned into whole cycles at 250 MHz (rounded up).
  localparam int BRP_CLK_PERIOD_NS = 4;
  localparam int BRP_ROM_ACCESS_NS = 120;
  localparam int BRP_ROM_ACCESS_CYC = (BRP_ROM_ACCESS_NS + BRP_CLK_PERIOD_NS - 1) / BRP_CLK_PERIOD_NS;
  localparam int BRP_CNT_W = 8;
  localparam logic [BRP_CNT_W-1:0] BRP_WAIT_LAST = BRP_CNT_W'(BRP_ROM_ACCESS_CYC - 1);
  localparam logic [BRP_CNT_W-1:0] BRP_CNT_ZERO = 8'h00;
  localparam logic [BRP_CNT_W-1:0] BRP_CNT_ONE = 8'h01;

  localparam logic [BRP_BYTE_W-1:0] BRP_BYTE_ZERO = 8'h00;
  localparam logic [BRP_ADDR_W-1:0] BRP_ADDR_ZERO = 16'h0000;

  // Pin group of the ROM/LED port; enables are active low (low = device drives).
  typedef struct packed {
    logic [BRP_BYTE_W-1:0] portOut;
    logic portOe_n;
    logic highAddrLatchStrobe_n;
    logic lowAddrLatchStrobe_n;
    logic romOutputEnable_n;
  } brp_pins_t;

  typedef enum logic [2:0] {
    BRP_IDLE = 3'b000,
    BRP_HIGH = 3'b001,
    BRP_LOW = 3'b010,
    BRP_WAIT = 3'b011,
    BRP_DONE = 3'b100
  } brp_state_t;

endpackage : brp_pkg
`default_nettype wire

// *** hw/brp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module brp_sync
  import brp_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule : brp_sync
`default_nettype wire

// *** hw/brp_rom_port.sv ***
// Notes on behaviour
// - One shared 8-bit port carries address bytes out and read data back.
// - While the high strobe is low, the port drives the upper address byte.
// - While the low strobe is low, the port drives the lower address byte.
// - When no ROM access runs, the port shows the LED levels.
// - Output enable is active low; device drivers release the port while active.
// - The high strobe pulses low so the latch captures the upper byte.
`timescale 1ns/1ns
`default_nettype none
module brp_rom_port
  import brp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic readReq,
  input wire logic [BRP_ADDR_W-1:0] readAddr,
  output logic readReady,
  output logic readDone,
  output logic [BRP_BYTE_W-1:0] readData,
  input wire logic [BRP_BYTE_W-1:0] ledLevels,
  input wire logic [BRP_BYTE_W-1:0] romAddrDataPortIn,
  output logic [BRP_BYTE_W-1:0] romAddrDataPortOut,
  output logic romAddrDataPortOe_n,
  output logic highAddrLatchStrobe_n,
  output logic lowAddrLatchStrobe_n,
  output logic romOutputEnable_n
);

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  logic [BRP_BYTE_W-1:0] portInSync;

  // The pins are outside the clock domain, so they pass two flip-flops.
  // This adds two cycles to the data path that the wait count does not cover; the byte taken is the pin two cycles before the enable rises.
  // Only the end of the enable window reads the synchronised byte; other cycles ignore it.
  brp_sync #(.W(BRP_BYTE_W)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(romAddrDataPortIn),
    .syncOut(portInSync)
  );

  // ==========================================================================
  // Access sequencer
  // ==========================================================================
  brp_state_t state_reg;
  brp_state_t state_next;
  logic [BRP_ADDR_W-1:0] addr_reg;
  logic [BRP_ADDR_W-1:0] addr_next;
  logic [BRP_CNT_W-1:0] cnt_reg;
  logic [BRP_CNT_W-1:0] cnt_next;
  // The flag waitLast marks the final cycle of the enable window.
  logic waitLast;

  // An access runs idle, high byte, low byte, then the enable window and one turnaround cycle.
  // The address is held in addr_reg, so the request lines may change once the request is taken.
  // The whole access takes a fixed number of cycles; there is no early end and no abort.
  assign waitLast = (state_reg == BRP_WAIT) && (cnt_reg == BRP_WAIT_LAST);

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      BRP_IDLE: begin
        // Requests are looked at only here, so one made while busy is dropped, not queued.
        if (readReq) begin
          addr_next = readAddr;
          state_next = BRP_HIGH;
        end
      end
      BRP_HIGH: begin
        state_next = BRP_LOW;
      end
      BRP_LOW: begin
        state_next = BRP_WAIT;
        cnt_next = BRP_CNT_ZERO;
      end
      BRP_WAIT: begin
        // Counting from zero keeps the enable low for exactly the access time in cycles.
        cnt_next = cnt_reg + BRP_CNT_ONE;
        if (waitLast) begin
          state_next = BRP_DONE;
        end
      end
      BRP_DONE: begin
        // The port stays released for one more cycle here.
        state_next = BRP_IDLE;
      end
      default: begin
        state_next = BRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BRP_IDLE;
      addr_reg <= BRP_ADDR_ZERO;
      cnt_reg <= BRP_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================================
  // Read data capture
  // ==========================================================================
  logic [BRP_BYTE_W-1:0] data_reg;
  logic [BRP_BYTE_W-1:0] data_next;
  logic done_reg;
  logic done_next;

  // The byte is kept until the next access ends, so a slow consumer may read it late.
  // The done pulse lasts one cycle and rises on the same edge that loads the byte.
  always_comb begin
    data_next = data_reg;
    done_next = 1'b0;
    if (waitLast) begin
      // Sampled while enable still stands; the synchronised byte is the pin from two cycles earlier.
      data_next = portInSync;
      done_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= BRP_BYTE_ZERO;
      done_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      done_reg <= done_next;
    end
  end

  // ==========================================================================
  // Port drivers
  // ==========================================================================
  brp_pins_t pins_reg;
  brp_pins_t pins_next;

  // Every cycle without a ROM step falls back to the LED levels with the drivers on.
  always_comb begin
    pins_next.highAddrLatchStrobe_n = 1'b1;
    pins_next.lowAddrLatchStrobe_n = 1'b1;
    pins_next.romOutputEnable_n = 1'b1;
    pins_next.portOe_n = 1'b0;
    pins_next.portOut = ledLevels;
    unique case (state_reg)
      BRP_IDLE: begin
        // The high byte goes out with its strobe on the edge that takes the request.
        if (readReq) begin
          pins_next.highAddrLatchStrobe_n = 1'b0;
          pins_next.portOut = readAddr[BRP_ADDR_HI_MSB:BRP_ADDR_HI_LSB];
        end
      end
      BRP_HIGH: begin
        pins_next.lowAddrLatchStrobe_n = 1'b0;
        pins_next.portOut = addr_reg[BRP_ADDR_LO_MSB:BRP_ADDR_LO_LSB];
      end
      BRP_LOW: begin
        // Drivers let go in the same cycle as the enable falls, so the ROM never meets them.
        pins_next.romOutputEnable_n = 1'b0;
        pins_next.portOe_n = 1'b1;
        pins_next.portOut = BRP_BYTE_ZERO;
      end
      BRP_WAIT: begin
        // The enable rises on the edge that loads the byte, so data is taken before the ROM lets go.
        pins_next.romOutputEnable_n = waitLast;
        pins_next.portOe_n = 1'b1;
        pins_next.portOut = BRP_BYTE_ZERO;
      end
      BRP_DONE: begin
        // One turnaround cycle with the port released avoids a drive fight with the ROM.
        pins_next.portOe_n = 1'b1;
        pins_next.portOut = BRP_BYTE_ZERO;
      end
      default: begin
        // An illegal state code shows the LED levels, as idle does.
        pins_next.portOut = ledLevels;
      end
    endcase
  end

  // Out of reset the port is released and every strobe and enable is idle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_reg.portOut <= BRP_BYTE_ZERO;
      pins_reg.portOe_n <= 1'b1;
      pins_reg.highAddrLatchStrobe_n <= 1'b1;
      pins_reg.lowAddrLatchStrobe_n <= 1'b1;
      pins_reg.romOutputEnable_n <= 1'b1;
    end else begin
      pins_reg <= pins_next;
    end
  end

  // ==========================================================================
  // Handshake and data outputs
  // ==========================================================================
  // Ready comes straight from the state register, so a request may follow in the cycle it rises.
  assign readReady = (state_reg == BRP_IDLE);
  assign readDone = done_reg;
  assign readData = data_reg;

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  // Each pin follows a flip-flop, so no decode glitch can reach a latch strobe.
  assign romAddrDataPortOut = pins_reg.portOut;
  assign romAddrDataPortOe_n = pins_reg.portOe_n;
  assign highAddrLatchStrobe_n = pins_reg.highAddrLatchStrobe_n;
  assign lowAddrLatchStrobe_n = pins_reg.lowAddrLatchStrobe_n;
  assign romOutputEnable_n = pins_reg.romOutputEnable_n;

endmodule : brp_rom_port
`default_nettype wire

// *** tb/brp_rom_port_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module brp_rom_port_chk
  import brp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic readReq,
  input wire logic [BRP_ADDR_W-1:0] readAddr,
  input wire logic readReady,
  input wire logic readDone,
  input wire logic [BRP_BYTE_W-1:0] readData,
  input wire logic [BRP_BYTE_W-1:0] ledLevels,
  input wire logic [BRP_BYTE_W-1:0] romAddrDataPortIn,
  input wire logic [BRP_BYTE_W-1:0] romAddrDataPortOut,
  input wire logic romAddrDataPortOe_n,
  input wire logic highAddrLatchStrobe_n,
  input wire logic lowAddrLatchStrobe_n,
  input wire logic romOutputEnable_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence sAddr;
    !highAddrLatchStrobe_n ##1 (!lowAddrLatchStrobe_n && highAddrLatchStrobe_n);
  endsequence
  sequence sWait;
    !romOutputEnable_n [*8];
  endsequence
  chk_read_order: assert property (readReq && readReady |=> sAddr ##1 sWait ##22 !romOutputEnable_n ##1 readDone)
    else $error("read sequence out of order");
  chk_high_byte: assert property (!highAddrLatchStrobe_n |-> !romAddrDataPortOe_n &&
    romAddrDataPortOut == $past(readAddr[BRP_ADDR_HI_MSB:BRP_ADDR_HI_LSB])) else $error("bad high address byte");
  chk_low_byte: assert property (!lowAddrLatchStrobe_n |-> !romAddrDataPortOe_n &&
    romAddrDataPortOut == $past(readAddr[BRP_ADDR_LO_MSB:BRP_ADDR_LO_LSB], 2)) else $error("bad low address byte");
  chk_port_release: assert property (!romOutputEnable_n |-> romAddrDataPortOe_n)
    else $error("port driven during output enable");
  chk_led_idle: assert property (readReady && $past(readReady) && $past(rst_n) |-> !romAddrDataPortOe_n &&
    romAddrDataPortOut == $past(ledLevels)) else $error("idle port not showing leds");
  chk_done_pulse: assert property (readDone |=> !readDone && readReady)
    else $error("done not a single pulse");
  chk_busy_refuse: assert property (!readReady |=> highAddrLatchStrobe_n)
    else $error("request taken while busy");
endmodule : brp_rom_port_chk
bind brp_rom_port brp_rom_port_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .readReq(readReq),
  .readAddr(readAddr), .readReady(readReady), .readDone(readDone), .readData(readData), .ledLevels(ledLevels),
  .romAddrDataPortIn(romAddrDataPortIn), .romAddrDataPortOut(romAddrDataPortOut),
  .romAddrDataPortOe_n(romAddrDataPortOe_n), .highAddrLatchStrobe_n(highAddrLatchStrobe_n),
  .lowAddrLatchStrobe_n(lowAddrLatchStrobe_n), .romOutputEnable_n(romOutputEnable_n));
`default_nettype wire

// *** tb/brp_rom_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module brp_rom_model
  import brp_pkg::*;
(
  input wire logic sys_clk,
  input wire brp_pins_t pins,
  output logic [BRP_BYTE_W-1:0] portWire
);
  logic [BRP_BYTE_W-1:0] hiReg, loReg, lastReg;
  always_ff @(posedge sys_clk) begin
    if (!pins.highAddrLatchStrobe_n) hiReg <= pins.portOut;
    if (!pins.lowAddrLatchStrobe_n) loReg <= pins.portOut;
    lastReg <= portWire;
  end
  // A released port toggles each cycle, so a stale byte can never pass for read data.
  always_comb portWire = !pins.portOe_n ? pins.portOut :
    (!pins.romOutputEnable_n ? (hiReg ^ loReg ^ 8'h3c) : ~lastReg);
endmodule : brp_rom_model
`default_nettype wire

// *** tb/test_boot_rom_mux_byte_port.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_boot_rom_mux_byte_port;
  import brp_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, readReq = 1'b0;
  logic [BRP_ADDR_W-1:0] readAddr = 16'h0000;
  logic [7:0] ledLevels = 8'h00, readData, portOut, portWire;
  logic readReady, readDone, portOe_n, hiStb_n, loStb_n, romOe_n;
  brp_pins_t pins;
  int failures = 0, compares = 0;
  assign pins = {portOut, portOe_n, hiStb_n, loStb_n, romOe_n};
  brp_rom_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .readReq(readReq), .readAddr(readAddr),
    .readReady(readReady), .readDone(readDone), .readData(readData), .ledLevels(ledLevels),
    .romAddrDataPortIn(portWire), .romAddrDataPortOut(portOut), .romAddrDataPortOe_n(portOe_n),
    .highAddrLatchStrobe_n(hiStb_n), .lowAddrLatchStrobe_n(loStb_n), .romOutputEnable_n(romOe_n));
  brp_rom_model rom_u (.sys_clk(sys_clk), .pins(pins), .portWire(portWire));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // With refuse set the request stays up with another address while busy; it must be ignored.
  task automatic read_byte(input logic [15:0] a, input logic refuse);
    int n;
    @(posedge sys_clk);
    readReq <= 1'b1;
    readAddr <= a;
    @(posedge sys_clk);
    readReq <= refuse;
    if (refuse) readAddr <= ~a;
    for (n = 0; n < 40 && readDone !== 1'b1; n++) @(posedge sys_clk) #1;
    // Two strobe cycles come before the enable window, and done follows its last cycle.
    check(8'(n), 8'(BRP_ROM_ACCESS_CYC + 2));
    check(readData, a[15:8] ^ a[7:0] ^ 8'h3c);
    @(posedge sys_clk);
    readReq <= 1'b0;
  endtask : read_byte
  // A reset in the enable window must end the access at once and leave the port released.
  task automatic reset_mid_read();
    @(posedge sys_clk);
    readReq <= 1'b1;
    readAddr <= 16'h5aa5;
    @(posedge sys_clk);
    readReq <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk) #1;
    check({2'b00, romOe_n, portOe_n, hiStb_n, loStb_n, readReady, readDone}, 8'h3e);
    check(readData, 8'h00);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    read_byte(16'h5aa5, 1'b0);
  endtask : reset_mid_read
  task automatic led_show(input logic [7:0] v);
    @(posedge sys_clk);
    ledLevels <= v;
    repeat (3) @(posedge sys_clk);
    #1 check(portOut, v);
    check({7'h00, portOe_n}, 8'h00);
  endtask : led_show
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    #4000 failures++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    led_show(8'h96);
    read_byte(16'ha55a, 1'b0);
    read_byte(16'h12f0, 1'b1);
    read_byte(16'hffff, 1'b0);
    reset_mid_read();
    led_show(8'h69);
    finish_test();
  end
endmodule : test_boot_rom_mux_byte_port
`default_nettype wire
